// ---- hdl/epr_sequencer.sv ----
// Pack presence, power grant and reset sequencer with APB registers
//
// Summary of operation
// (RULE_01) The pack raises its interrupt line high to ask for service; a low line means no request.
// (RULE_02) After the grant rises for a newly inserted pack, reset is driven high for 100 ms by default, then low.
// (RULE_03) Reset stays low at all times apart from that single post-grant pulse; the code pulses it again on each re-grant.
// (RULE_04) Software sets the reset pulse length in milliseconds; it resets to 100.
// (RULE_05) The pack runs only identification while the grant is low and full power once it is high.
// (RULE_06) The pack judges attachment from supply, ground and the grant.
// (RULE_07) The pack ties the presence lines low; low reads as inserted and high as removed.
// (RULE_08) Insertion on the presence lines sets an interrupt.
// (RULE_09) Removal on the presence lines sets an interrupt.
// (RULE_10) No grant, reset or link enable reaches the pack until presence shows insertion.
// (RULE_11) Interface buffers idle when no pack is present; the pack keeps its inputs at defined levels.
// (RULE_12) The pack drives battery-good low when its battery falls below the trip point.
// (RULE_13) A pack using wait states keeps them short.
// (RULE_14) A battery fault from the pack forces the grant low.
// (RULE_15) The reset pulse is timed by a counter started at the grant edge, cleared on grant or presence loss.
// (RULE_16) The pack holds its logic in reset while reset is high or the grant is low.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module epr_sequencer
  import epr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  pack_present_n,
  input  wire logic        pack_irq,
  input  wire logic        pack_battery_fault,
  input  wire logic        ext_battery_good,
  output logic             pack_power_grant,
  output logic             pack_reset,
  output logic             pack_link_en,
  output logic             irq
);

  typedef struct packed {
    epr_seq_type seq;
    logic        present;
    logic        irq_in;
    logic        fault;
    logic        grant_req;
    logic        link_req;
    logic        grant;
    logic        reset;
    logic        link_en;
    logic [15:0] rst_len;
    logic [15:0] ms_left;
    logic [4:0]  ev_stat;
    logic [4:0]  ev_mask;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
  } epr_state_type;

  epr_state_type r;
  epr_state_type next_r;
  epr_tick_if    tk ();

  epr_ms_tick u_ms_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk)
  );

  logic        present_now;
  logic        access;
  logic        wr;
  logic        rd;
  logic [4:0]  ev_set;
  logic [4:0]  ev_clr;
  logic [31:0] status_word;

  // Both contacts must be low before the pack counts as mated
  assign present_now = ~pack_present_n[0] & ~pack_present_n[1]; // [RULE_07]
  assign access      = psel & penable & ~r.ready;
  assign wr          = access & pwrite;
  assign rd          = access & ~pwrite;
  // Counter restarts on every grant edge
  assign tk.clear    = (r.seq != SEQ_RESET) || (next_r.seq != SEQ_RESET); // [RULE_15]

  always_comb begin
    status_word                   = ZERO_WORD;
    status_word[ST_PRESENT]       = r.present;
    status_word[ST_GRANT]         = r.grant;
    status_word[ST_RESET]         = r.reset;
    status_word[ST_FAULT]         = r.fault;
    status_word[ST_IRQ_IN]        = r.irq_in;
    status_word[ST_BATT_GOOD]     = ext_battery_good;
    status_word[ST_SEQ_LSB +: 2]  = r.seq;
  end

  always_comb begin
    next_r         = r;
    next_r.present = present_now;
    next_r.irq_in  = pack_irq;
    next_r.fault   = pack_battery_fault;
    ev_set         = EV_ZERO;
    ev_clr         = EV_ZERO;
    next_r.ready   = 1'b0;
    next_r.slverr  = 1'b0;

    if (present_now && !r.present) begin
      ev_set[EV_INSERT] = 1'b1; // [RULE_08]
    end
    if (!present_now && r.present) begin
      ev_set[EV_REMOVE] = 1'b1; // [RULE_09]
    end
    if (pack_irq && !r.irq_in && r.present) begin
      ev_set[EV_PACK_IRQ] = 1'b1; // [RULE_01]
    end
    if (pack_battery_fault && !r.fault && r.present) begin
      ev_set[EV_FAULT] = 1'b1;
    end

    // APB slave, answers one cycle into the access phase
    if (access) begin
      next_r.ready = 1'b1;
      next_r.rdata = ZERO_WORD;
      unique case (paddr)
        ADDR_CTRL: begin
          if (wr) begin
            next_r.grant_req = pwdata[CTRL_GRANT];
            next_r.link_req  = pwdata[CTRL_LINK_EN];
          end
          next_r.rdata[CTRL_GRANT]   = r.grant_req;
          next_r.rdata[CTRL_LINK_EN] = r.link_req;
        end
        ADDR_STATUS: begin
          next_r.rdata = status_word;
        end
        ADDR_IRQ_STAT: begin
          if (wr) begin
            ev_clr = pwdata[EV_W-1:0];
          end
          next_r.rdata[EV_W-1:0] = r.ev_stat;
        end
        ADDR_IRQ_MASK: begin
          if (wr) begin
            next_r.ev_mask = pwdata[EV_W-1:0];
          end
          next_r.rdata[EV_W-1:0] = r.ev_mask;
        end
        ADDR_RST_LEN: begin
          if (wr) begin
            next_r.rst_len = (pwdata[15:0] == MS_ZERO) ? MS_ONE : pwdata[15:0]; // [RULE_04]
          end
          next_r.rdata[15:0] = r.rst_len;
        end
        default: begin
          next_r.slverr = 1'b1;
        end
      endcase
    end

    // Sequencer for grant and reset pulse
    unique case (r.seq)
      SEQ_ABSENT: begin
        next_r.grant_req = 1'b0;
        if (r.present) begin
          next_r.seq = SEQ_IDLE; // [RULE_10]
        end
      end
      SEQ_IDLE: begin
        if (!r.present) begin
          next_r.seq = SEQ_ABSENT;
        end else if (r.grant_req && !r.fault) begin
          next_r.seq     = SEQ_RESET; // [RULE_02]
          next_r.ms_left = r.rst_len;
        end
      end
      SEQ_RESET: begin
        if (!r.present || !r.grant_req || r.fault) begin
          next_r.seq     = r.present ? SEQ_IDLE : SEQ_ABSENT; // [RULE_15]
          next_r.ms_left = MS_ZERO;
        end else if (tk.tick) begin
          if (r.ms_left == MS_ONE) begin
            next_r.seq            = SEQ_RUN; // [RULE_02]
            ev_set[EV_RST_DONE]   = 1'b1;
            next_r.ms_left        = MS_ZERO;
          end else begin
            next_r.ms_left = r.ms_left - MS_ONE;
          end
        end
      end
      SEQ_RUN: begin
        if (!r.present) begin
          next_r.seq = SEQ_ABSENT;
        end else if (!r.grant_req || r.fault) begin
          next_r.seq = SEQ_IDLE;
        end
      end
    endcase

    // A battery fault drops the grant and the request with it
    if (r.fault) begin
      next_r.grant_req = 1'b0; // [RULE_14]
    end

    next_r.grant   = r.present && !r.fault &&
                     (next_r.seq == SEQ_RESET || next_r.seq == SEQ_RUN); // [RULE_14]
    next_r.reset   = r.present && (next_r.seq == SEQ_RESET); // [RULE_03]
    next_r.link_en = r.present && r.link_req; // [RULE_10] [RULE_11]

    // Set wins over a clear in the same cycle
    next_r.ev_stat = (r.ev_stat & ~ev_clr) | ev_set;
    next_r.irq     = |(next_r.ev_stat & next_r.ev_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.seq     <= SEQ_ABSENT;
      r.rst_len <= RST_MS_RESET; // [RULE_04]
    end else begin
      r <= next_r;
    end
  end

  assign prdata           = r.rdata;
  assign pready           = r.ready;
  assign pslverr          = r.slverr;
  assign pack_power_grant = r.grant;
  assign pack_reset       = r.reset;
  assign pack_link_en     = r.link_en;
  assign irq              = r.irq;

endmodule

// ---- hdl/epr_pkg.sv ----
// Package: constants, register map and types for the pack power and reset sequencer
package epr_pkg;

  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned RST_DEF_MS    = 100;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam logic [15:0] RST_MS_RESET  = RST_DEF_MS[15:0];

  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_RST_LEN  = 8'h10;

  localparam int unsigned CTRL_GRANT    = 0;
  localparam int unsigned CTRL_LINK_EN  = 1;
  localparam int unsigned ST_PRESENT    = 0;
  localparam int unsigned ST_GRANT      = 1;
  localparam int unsigned ST_RESET      = 2;
  localparam int unsigned ST_FAULT      = 3;
  localparam int unsigned ST_IRQ_IN     = 4;
  localparam int unsigned ST_BATT_GOOD  = 5;
  localparam int unsigned ST_SEQ_LSB    = 8;

  localparam int unsigned EV_INSERT     = 0;
  localparam int unsigned EV_REMOVE     = 1;
  localparam int unsigned EV_PACK_IRQ   = 2;
  localparam int unsigned EV_FAULT      = 3;
  localparam int unsigned EV_RST_DONE   = 4;
  localparam int unsigned EV_W          = 5;

  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [4:0]  EV_ZERO       = 5'h00;
  localparam logic [15:0] MS_ZERO       = 16'h0000;
  localparam logic [15:0] MS_ONE        = 16'h0001;
  localparam logic [14:0] CYC_ZERO      = 15'h0000;
  localparam logic [14:0] CYC_LAST      = 15'(CYC_PER_MS - 1);

  typedef enum logic [1:0] {
    SEQ_ABSENT  = 2'b00,
    SEQ_IDLE    = 2'b01,
    SEQ_RESET   = 2'b10,
    SEQ_RUN     = 2'b11
  } epr_seq_type;

endpackage

// ---- hdl/epr_tick_if.sv ----
// Interface: millisecond tick between divider and sequencer
`timescale 1ns/1ps
interface epr_tick_if;
  logic clear;
  logic tick;
  modport divider (input clear, output tick);
  modport user    (output clear, input tick);
endinterface

// ---- hdl/epr_ms_tick.sv ----
// Divider that makes a one-cycle pulse each millisecond
`timescale 1ns/1ps
module epr_ms_tick
  import epr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  epr_tick_if.divider      tk
);

  typedef struct packed {
    logic [14:0] count;
    logic        tick;
  } epr_div_type;

  epr_div_type r;
  epr_div_type next_r;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (tk.clear) begin
      next_r.count = CYC_ZERO;
    end else if (r.count == CYC_LAST) begin
      next_r.count = CYC_ZERO;
      next_r.tick  = 1'b1;
    end else begin
      next_r.count = r.count + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tk.tick = r.tick;

endmodule

// ---- sim/epr_sequencer_chk.sv ----
// Checker: port assertions for the pack sequencer
`timescale 1ns/1ps
module epr_sequencer_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [1:0] pack_present_n,
  input wire logic       pack_battery_fault,
  input wire logic       pack_power_grant,
  input wire logic       pack_reset,
  input wire logic       pack_link_en
);
  logic [15:0] hi_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt <= 16'h0000;
    else if (!pack_reset) hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h0001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_absent;
    (pack_present_n != 2'b00) [*4];
  endsequence
  a_apb_answer: assert property (s_access |=> pready) else $error("no apb answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_reset_in_grant: assert property (pack_reset |-> pack_power_grant)
    else $error("reset without grant");
  a_reset_rise: assert property ($rose(pack_reset) |-> $rose(pack_power_grant))
    else $error("reset not started by grant");
  a_absent_idle: assert property (s_absent |-> !pack_power_grant && !pack_link_en && !pack_reset)
    else $error("drive while absent");
  a_fault_off: assert property (pack_battery_fault [*4] |-> !pack_power_grant)
    else $error("grant during fault");
  a_pulse_len: assert property ($fell(pack_reset) && pack_power_grant && !pack_battery_fault
    && pack_present_n == 2'b00 |-> hi_cnt >= 16'h4E16) else $error("reset pulse short");
  a_single_pulse: assert property ($past(pack_power_grant) && pack_power_grant && !pack_reset
    |=> !pack_reset) else $error("second reset pulse");
endmodule
bind epr_sequencer epr_sequencer_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .pack_present_n(pack_present_n),
  .pack_battery_fault(pack_battery_fault), .pack_power_grant(pack_power_grant),
  .pack_reset(pack_reset), .pack_link_en(pack_link_en));

// ---- sim/epr_pack_model.sv ----
// Expansion pack model on the connector side
`timescale 1ns/1ps
module epr_pack_model (
  input wire logic        attach,
  input wire logic        fault,
  input wire logic        req,
  input wire logic        batt_low,
  input wire logic        pack_power_grant,
  input wire logic        pack_reset,
  output logic      [1:0] pack_present_n,
  output logic            pack_irq,
  output logic            pack_battery_fault,
  output logic            ext_battery_good,
  output logic            pack_on
);
  // Pulled high by the main unit when absent
  assign pack_present_n     = attach ? 2'b00 : 2'b11;
  assign pack_irq           = attach & req;
  assign pack_battery_fault = attach ? fault : 1'b1;
  assign ext_battery_good   = attach & !batt_low;
  assign pack_on            = attach & pack_power_grant & !pack_reset;
  // No wait-state path on this pack, so it never holds the system bus
endmodule

// ---- sim/test_expansion_presence_power_reset.sv ----
// Testbench for the pack presence, power and reset sequencer
`timescale 1ns/1ps
module test_expansion_presence_power_reset;
  import epr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        grant, rst, link, irq, attach, fault, req, blow, p_irq, p_flt, p_good, p_on;
  logic [1:0]  pres_n;
  int          error_cnt, n_checks, cyc;
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  epr_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pack_present_n(pres_n), .pack_irq(p_irq), .pack_battery_fault(p_flt),
    .ext_battery_good(p_good), .pack_power_grant(grant), .pack_reset(rst),
    .pack_link_en(link), .irq(irq));
  epr_pack_model pack_u (.attach(attach), .fault(fault), .req(req), .batt_low(blow),
    .pack_power_grant(grant), .pack_reset(rst), .pack_present_n(pres_n), .pack_irq(p_irq),
    .pack_battery_fault(p_flt), .ext_battery_good(p_good), .pack_on(p_on));
  task summarize;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && cyc < 60000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, ZERO_WORD);
    chk(nm, e, rd & m);
  endtask
  task t_reset;
    chk("outs", 32'h0, {28'h0, grant, rst, link, irq});
    rdc("len", ADDR_RST_LEN, 32'hFFFF, 32'h64);
    rdc("bad", 8'h40, 32'hFFFFFFFF, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_RST_LEN, 32'h0);
    rdc("len0", ADDR_RST_LEN, 32'hFFFF, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h3);
    repeat (5) @(posedge pclk);
    chk("absent", 32'h0, {29'h0, grant, rst, link});
    apb(1'b1, ADDR_CTRL, 32'h0);
  endtask
  task t_insert;
    apb(1'b1, ADDR_IRQ_MASK, 32'h1F);
    attach <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("ins", ADDR_IRQ_STAT, 32'h1, 32'h1);
    rdc("stat", ADDR_STATUS, 32'h21, 32'h21);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
    rdc("clr", ADDR_IRQ_STAT, 32'h1F, 32'h0);
  endtask
  task t_pulse;
    int n;
    apb(1'b1, ADDR_RST_LEN, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h3);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rst !== 1'b1 && n < 8);
    chk("on", 32'h7, {29'h0, grant, rst, link});
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rst === 1'b1 && n < 21000);
    chk("width", 32'h1, {31'h0, n > 19990 && n < 20010});
    chk("after", 32'h5, {29'h0, grant, rst, link});
    rdc("done", ADDR_IRQ_STAT, 32'h10, 32'h10);
    repeat (50) @(posedge pclk);
    chk("low", 32'h0, {31'h0, rst});
  endtask
  task t_pack_irq;
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
    req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("masked", 32'h0, {31'h0, irq});
    rdc("pirq", ADDR_IRQ_STAT, 32'h4, 32'h4);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    repeat (3) @(posedge pclk);
    chk("unmask", 32'h1, {31'h0, irq});
    req <= 1'b0;
    apb(1'b1, ADDR_IRQ_STAT, 32'h4);
    repeat (3) @(posedge pclk);
    chk("cleared", 32'h0, {31'h0, irq});
    blow <= 1'b1;
    rdc("bgood", ADDR_STATUS, 32'h20, 32'h0);
    blow <= 1'b0;
    rdc("bgood1", ADDR_STATUS, 32'h20, 32'h20);
  endtask
  task t_fault_remove;
    fault <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("flt", 32'h0, {31'h0, grant});
    rdc("ctrl", ADDR_CTRL, 32'h1, 32'h0);
    rdc("fev", ADDR_IRQ_STAT, 32'h8, 32'h8);
    fault <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk("regrant", 32'h1, {31'h0, rst});
    attach <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("gone", 32'h0, {30'h0, grant, rst});
    rdc("rem", ADDR_IRQ_STAT, 32'h2, 32'h2);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {attach, fault, req, blow, error_cnt, n_checks, cyc} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_insert();
    t_pulse();
    t_pack_irq();
    t_fault_remove();
    summarize();
  end
endmodule
